/* File: src/dcpm_pin_arb.sv */
// Output arbiter for one shared pin, requester 0 has highest priority
`timescale 1ns/1ns
module dcpm_pin_arb #(
  parameter int N = 2
) (
  input wire logic [N-1:0] i_req_oe,
  input wire logic [N-1:0] i_req_out,
  output logic o_oe,
  output logic o_out
);
  always_comb begin
    o_oe = |i_req_oe;
    o_out = 1'b0;
    // Walk low priority first so the highest requester wins
    for (int i = N - 1; i >= 0; i--) begin
      if (i_req_oe[i]) begin
        o_out = i_req_out[i];
      end
    end
  end
endmodule

/* File: src/dcpm_pkg.sv */
// Types shared by the device config block
package dcpm_pkg;
  typedef enum logic [3:0] {
    REG_BOOT_A = 4'b0000, REG_BOOT_B = 4'b0001, REG_HPI = 4'b0010, REG_AMSB = 4'b0011,
    REG_AUMB = 4'b0100, REG_TCS = 4'b0101, REG_MUTE0 = 4'b0110, REG_MUTE1 = 4'b0111,
    REG_MUTE2 = 4'b1000, REG_BRIDGE = 4'b1001, REG_PINOPT = 4'b1010, REG_STATUS = 4'b1011,
    REG_NONE = 4'b1111
  } dcpm_reg_type;
  typedef enum logic [1:0] {
    SP0_FULL = 2'b00, SP0_I2C1 = 2'b01, SP0_OFF = 2'b10
  } dcpm_sp0_opt_type;
  typedef enum logic [2:0] {
    SP1_5PIN = 3'b000, SP1_4PIN_SCS = 3'b001, SP1_4PIN_ENA = 3'b010, SP1_3PIN = 3'b011,
    SP1_OFF = 3'b100
  } dcpm_sp1_mode_type;
endpackage

/* File: src/dcpm_regs.svh */
// Register map, field positions and reset values of the device config block
`ifndef DCPM_REGS_SVH
`define DCPM_REGS_SVH
`define DCPM_ADDR_BOOT_A 32'h40000000
`define DCPM_ADDR_BOOT_B 32'h40000004
`define DCPM_ADDR_HPI 32'h40000008
`define DCPM_ADDR_AMSB 32'h4000000C
`define DCPM_ADDR_AUMB 32'h40000010
`define DCPM_ADDR_TCS 32'h40000014
`define DCPM_ADDR_MUTE0 32'h40000018
`define DCPM_ADDR_MUTE1 32'h4000001C
`define DCPM_ADDR_MUTE2 32'h40000020
`define DCPM_ADDR_BRIDGE 32'h40000024
`define DCPM_ADDR_PINOPT 32'h40000028
`define DCPM_ADDR_STATUS 32'h4000002C
`define DCPM_HPI_EN 0
`define DCPM_HPI_HOST_NONMUX_MODE_BIT 1
`define DCPM_HPI_HALF 2
`define DCPM_HPI_SEC 3
`define DCPM_HPI_RST 4'h0
`define DCPM_BYTE_RST 8'h00
`define DCPM_TCS_CH0 0
`define DCPM_TCS_CH1 4
`define DCPM_TCS_RST 8'h77
`define DCPM_NUM_EVENTS 3'h6
`define DCPM_MUTE_RST 3'h0
`define DCPM_BRIDGE_RST 1'b0
`define DCPM_PO_SP0 0
`define DCPM_PO_SP1 2
`define DCPM_PO_OWN 8
`define DCPM_PINOPT_RST 16'h0010
`define DCPM_ST_A0 0
`define DCPM_ST_A1 8
`define DCPM_A0_5PIN 5'h0B
`define DCPM_A0_4PIN 5'h0C
`define DCPM_A0_3PIN 5'h0D
`define DCPM_A0_OFF 5'h10
`define DCPM_A1_ON 3'h4
`define DCPM_A1_OFF 3'h6
`endif

/* File: src/dcpm_top.sv */
// Device configuration registers and shared-pin multiplexer
`timescale 1ns/1ns
`include "dcpm_regs.svh"

// Operation
// - Boot registers capture eight pins each at reset release
// - Host port config sets enable and mode
// - Top address byte used in nonmux or secure
// - Upper middle byte used likewise
// - Timer capture channels pick audio transfer events
// - Each audio port picks its mute pin
// - Bridge control register drives bridge reset
// - Serial port 0 options one and two
// - Port disabled: I2C owns pins, data-out stays
// - Serial port 1 mode limits audio pins
// - Shared audio pins assigned per pin
// - Multiplexed host keeps 32-bit memory data
// - Nonmux host: upper pins become host address
// - Any output request drives, priority picks value
module dcpm_top (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [7:0] i_boot_pins_a,
  input wire logic [7:0] i_boot_pins_b,
  output logic o_host_enable,
  output logic o_host_nonmux,
  output logic o_host_halfword,
  output logic o_host_addr_valid,
  output logic [7:0] o_host_addr_top,
  output logic [7:0] o_host_addr_mid,
  input wire logic [5:0] i_audio_dma_events,
  output logic [1:0] o_capture_trig,
  input wire logic [7:0] i_mute_pins,
  output logic [2:0] o_audio_mute_in,
  output logic o_bridge_reset,
  input wire logic [3:0] i_sp0_oe,
  input wire logic [3:0] i_sp0_out,
  input wire logic [3:0] i_i2c_oe,
  input wire logic [3:0] i_i2c_out,
  input wire logic [3:0] i_sp0_pin_in,
  output logic [3:0] o_sp0_pin_out,
  output logic [3:0] o_sp0_pin_oe_n,
  output logic [3:0] o_sp0_pin_sync,
  input wire logic i_simo_oe,
  input wire logic i_simo_out,
  output logic o_simo_pin_out,
  output logic o_simo_pin_oe_n,
  input wire logic [10:0] i_au0_oe,
  input wire logic [10:0] i_au0_out,
  input wire logic [10:0] i_sec_oe,
  input wire logic [10:0] i_sec_out,
  input wire logic [4:0] i_sp1_oe,
  input wire logic [4:0] i_sp1_out,
  input wire logic [10:0] i_ax_pin_in,
  output logic [10:0] o_ax_pin_out,
  output logic [10:0] o_ax_pin_oe_n,
  output logic [10:0] o_ax_pin_sync,
  input wire logic i_mem_oe_hi,
  input wire logic [15:0] i_mem_out_hi,
  input wire logic [15:0] i_md_pin_in,
  output logic [15:0] o_md_pin_out,
  output logic [15:0] o_md_pin_oe_n,
  output logic [15:0] o_md_pin_sync,
  output logic o_mem_wide
);
  import dcpm_pkg::*;

  logic [7:0] boot_a_q, boot_b_q;
  logic boot_done_q;
  logic [3:0] hpi_q;
  logic [7:0] amsb_q, aumb_q, tcs_q;
  logic [2:0] mute_q [3];
  logic brg_q;
  logic [15:0] pinopt_q;
  logic wr_q, rd_q, hready_q, addr_valid_q, simo_out_q, simo_oe_n_q, wide_q;
  dcpm_reg_type idx_q;
  logic [31:0] hrdata_q, rd_word;
  logic [1:0] trig_q;
  logic [2:0] mute_in_q;
  logic [3:0] sp0_out_q, sp0_oe_n_q, sp0_in_q, sp0_use, i2c_use, spi0_req, i2c_req, sp0_oe, sp0_val;
  logic [10:0] ax_out_q, ax_oe_n_q, ax_in_q, sp1_x, own_x, au0_req, sec_req, sp1_req, sp1_out_x, ax_oe, ax_val;
  logic [15:0] md_out_q, md_oe_n_q, md_in_q;
  logic [4:0] sp1_use, a0_max;
  logic [2:0] a1_max;
  logic addr_ok, wr_en;
  dcpm_sp0_opt_type sp0_opt;
  dcpm_sp1_mode_type sp1_mode;

  function automatic dcpm_reg_type reg_decode(input logic [31:0] a);
    unique case (a)
      `DCPM_ADDR_BOOT_A: return REG_BOOT_A;
      `DCPM_ADDR_BOOT_B: return REG_BOOT_B;
      `DCPM_ADDR_HPI: return REG_HPI;
      `DCPM_ADDR_AMSB: return REG_AMSB;
      `DCPM_ADDR_AUMB: return REG_AUMB;
      `DCPM_ADDR_TCS: return REG_TCS;
      `DCPM_ADDR_MUTE0: return REG_MUTE0;
      `DCPM_ADDR_MUTE1: return REG_MUTE1;
      `DCPM_ADDR_MUTE2: return REG_MUTE2;
      `DCPM_ADDR_BRIDGE: return REG_BRIDGE;
      `DCPM_ADDR_PINOPT: return REG_PINOPT;
      `DCPM_ADDR_STATUS: return REG_STATUS;
      default: return REG_NONE;
    endcase
  endfunction

  // Select outside the source range gives a quiet zero
  function automatic logic pick(input logic [7:0] v, input logic [2:0] s, input logic [2:0] n);
    return (s < n) ? v[s] : 1'b0;
  endfunction

  assign addr_ok = i_hsel && i_htrans[1] && i_hready;
  assign wr_en = wr_q && i_hready;
  assign sp0_opt = dcpm_sp0_opt_type'(pinopt_q[`DCPM_PO_SP0 +: 2]);
  assign sp1_mode = dcpm_sp1_mode_type'(pinopt_q[`DCPM_PO_SP1 +: 3]);

  // Reads take one wait state so a write just before is always seen
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= REG_NONE;
      hready_q <= 1'b1;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_q <= addr_ok && i_hwrite;
      rd_q <= addr_ok && !i_hwrite;
      hready_q <= !(addr_ok && !i_hwrite);
      if (addr_ok) begin
        idx_q <= reg_decode(i_haddr);
      end
      if (rd_q) begin
        hrdata_q <= rd_word;
      end
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    unique case (idx_q)
      REG_BOOT_A: rd_word[7:0] = boot_a_q;
      REG_BOOT_B: rd_word[7:0] = boot_b_q;
      REG_HPI: rd_word[3:0] = hpi_q;
      REG_AMSB: rd_word[7:0] = amsb_q;
      REG_AUMB: rd_word[7:0] = aumb_q;
      REG_TCS: rd_word[7:0] = tcs_q;
      REG_MUTE0: rd_word[2:0] = mute_q[0];
      REG_MUTE1: rd_word[2:0] = mute_q[1];
      REG_MUTE2: rd_word[2:0] = mute_q[2];
      REG_BRIDGE: rd_word[0] = brg_q;
      REG_PINOPT: rd_word[15:0] = pinopt_q;
      REG_STATUS: begin
        rd_word[`DCPM_ST_A0 +: 5] = a0_max;
        rd_word[`DCPM_ST_A1 +: 3] = a1_max;
      end
      REG_NONE: rd_word = 32'h00000000;
    endcase
  end

  // Strap levels are caught on the first edge after release, never under reset
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      boot_done_q <= 1'b0;
      boot_a_q <= 8'h00;
      boot_b_q <= 8'h00;
    end else if (!boot_done_q) begin
      boot_done_q <= 1'b1;
      boot_a_q <= i_boot_pins_a;
      boot_b_q <= i_boot_pins_b;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hpi_q <= `DCPM_HPI_RST;
      amsb_q <= `DCPM_BYTE_RST;
      aumb_q <= `DCPM_BYTE_RST;
      tcs_q <= `DCPM_TCS_RST;
      mute_q[0] <= `DCPM_MUTE_RST;
      mute_q[1] <= `DCPM_MUTE_RST;
      mute_q[2] <= `DCPM_MUTE_RST;
      brg_q <= `DCPM_BRIDGE_RST;
      pinopt_q <= `DCPM_PINOPT_RST;
    end else if (wr_en) begin
      unique case (idx_q)
        REG_HPI: hpi_q <= i_hwdata[3:0];
        REG_AMSB: amsb_q <= i_hwdata[7:0];
        REG_AUMB: aumb_q <= i_hwdata[7:0];
        REG_TCS: tcs_q <= i_hwdata[7:0];
        REG_MUTE0: mute_q[0] <= i_hwdata[2:0];
        REG_MUTE1: mute_q[1] <= i_hwdata[2:0];
        REG_MUTE2: mute_q[2] <= i_hwdata[2:0];
        REG_BRIDGE: brg_q <= i_hwdata[0];
        REG_PINOPT: pinopt_q <= i_hwdata[15:0];
        // Boot capture and status words are read only
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      addr_valid_q <= 1'b0;
      trig_q <= 2'b00;
      mute_in_q <= 3'b000;
      wide_q <= 1'b1;
    end else begin
      addr_valid_q <= hpi_q[`DCPM_HPI_HOST_NONMUX_MODE_BIT] || hpi_q[`DCPM_HPI_SEC];
      trig_q[0] <= pick({2'b00, i_audio_dma_events}, tcs_q[`DCPM_TCS_CH0 +: 3], `DCPM_NUM_EVENTS);
      trig_q[1] <= pick({2'b00, i_audio_dma_events}, tcs_q[`DCPM_TCS_CH1 +: 3], `DCPM_NUM_EVENTS);
      for (int p = 0; p < 3; p++) begin
        mute_in_q[p] <= pick(i_mute_pins, mute_q[p], 3'h7) || (mute_q[p] == 3'h7 && i_mute_pins[7]);
      end
      wide_q <= !hpi_q[`DCPM_HPI_HOST_NONMUX_MODE_BIT];
    end
  end

  always_comb begin
    unique case (sp0_opt)
      SP0_FULL: begin
        sp0_use = 4'b1111;
        i2c_use = 4'b0000;
      end
      SP0_I2C1: begin
        sp0_use = 4'b0011;
        i2c_use = 4'b1100;
      end
      default: begin
        sp0_use = 4'b0000;
        i2c_use = 4'b1111;
      end
    endcase
  end

  // Pin order per bit: chip select, enable, clock, data in, data out
  always_comb begin
    unique case (sp1_mode)
      SP1_5PIN: begin
        sp1_use = 5'b11111;
        a0_max = `DCPM_A0_5PIN;
      end
      SP1_4PIN_SCS: begin
        sp1_use = 5'b11101;
        a0_max = `DCPM_A0_4PIN;
      end
      SP1_4PIN_ENA: begin
        sp1_use = 5'b11110;
        a0_max = `DCPM_A0_4PIN;
      end
      SP1_3PIN: begin
        sp1_use = 5'b11100;
        a0_max = `DCPM_A0_3PIN;
      end
      default: begin
        sp1_use = 5'b00000;
        a0_max = `DCPM_A0_OFF;
      end
    endcase
    a1_max = (sp1_use == 5'b00000) ? `DCPM_A1_OFF : `DCPM_A1_ON;
  end

  assign spi0_req = i_sp0_oe & sp0_use;
  assign i2c_req = i_i2c_oe & i2c_use;
  assign sp1_x = {6'h00, sp1_use};
  assign sp1_out_x = {6'h00, i_sp1_out};
  // Owner bits exist only for pins that a second audio port can reach
  assign own_x = {pinopt_q[`DCPM_PO_OWN +: 8], 3'h0};
  assign au0_req = i_au0_oe & ~sp1_x & ~own_x;
  assign sec_req = i_sec_oe & ~sp1_x & own_x;
  assign sp1_req = {6'h00, i_sp1_oe & sp1_use};

  for (genvar k = 0; k < 4; k++) begin : g_sp0
    dcpm_pin_arb #(.N(2)) u_arb (
      .i_req_oe({i2c_req[k], spi0_req[k]}),
      .i_req_out({i_i2c_out[k], i_sp0_out[k]}),
      .o_oe(sp0_oe[k]),
      .o_out(sp0_val[k])
    );
  end

  for (genvar k = 0; k < 11; k++) begin : g_ax
    dcpm_pin_arb #(.N(3)) u_arb (
      .i_req_oe({sp1_req[k], sec_req[k], au0_req[k]}),
      .i_req_out({sp1_out_x[k], i_sec_out[k], i_au0_out[k]}),
      .o_oe(ax_oe[k]),
      .o_out(ax_val[k])
    );
  end

  // Pins leave through flops; the extra cycle is harmless at these pin rates
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sp0_out_q <= 4'h0;
      sp0_oe_n_q <= 4'hF;
      simo_out_q <= 1'b0;
      simo_oe_n_q <= 1'b1;
      ax_out_q <= 11'h000;
      ax_oe_n_q <= 11'h7FF;
    end else begin
      sp0_out_q <= sp0_val;
      sp0_oe_n_q <= ~sp0_oe;
      simo_out_q <= i_simo_out;
      simo_oe_n_q <= !i_simo_oe;
      ax_out_q <= ax_val;
      ax_oe_n_q <= ~ax_oe;
    end
  end

  // Memory bus parking would fight the host address inputs in nonmux mode
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      md_out_q <= 16'h0000;
      md_oe_n_q <= 16'hFFFF;
    end else begin
      md_out_q <= i_mem_out_hi;
      md_oe_n_q <= {16{!(i_mem_oe_hi && !hpi_q[`DCPM_HPI_HOST_NONMUX_MODE_BIT])}};
    end
  end

  // One registered copy of each pin feeds every sharer at once
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sp0_in_q <= 4'h0;
      ax_in_q <= 11'h000;
      md_in_q <= 16'h0000;
    end else begin
      sp0_in_q <= i_sp0_pin_in;
      ax_in_q <= i_ax_pin_in;
      md_in_q <= i_md_pin_in;
    end
  end

  assign o_hrdata = hrdata_q;
  assign o_hreadyout = hready_q;
  assign o_hresp = 1'b0;
  assign o_host_enable = hpi_q[`DCPM_HPI_EN];
  assign o_host_nonmux = hpi_q[`DCPM_HPI_HOST_NONMUX_MODE_BIT];
  assign o_host_halfword = hpi_q[`DCPM_HPI_HALF];
  assign o_host_addr_valid = addr_valid_q;
  assign o_host_addr_top = amsb_q;
  assign o_host_addr_mid = aumb_q;
  assign o_capture_trig = trig_q;
  assign o_audio_mute_in = mute_in_q;
  assign o_bridge_reset = brg_q;
  assign o_sp0_pin_out = sp0_out_q;
  assign o_sp0_pin_oe_n = sp0_oe_n_q;
  assign o_sp0_pin_sync = sp0_in_q;
  assign o_simo_pin_out = simo_out_q;
  assign o_simo_pin_oe_n = simo_oe_n_q;
  assign o_ax_pin_out = ax_out_q;
  assign o_ax_pin_oe_n = ax_oe_n_q;
  assign o_ax_pin_sync = ax_in_q;
  assign o_md_pin_out = md_out_q;
  assign o_md_pin_oe_n = md_oe_n_q;
  assign o_md_pin_sync = md_in_q;
  assign o_mem_wide = wide_q;

  property p_boot_cap;
    @(posedge i_clock) disable iff (i_rst)
      $rose(boot_done_q) |-> boot_a_q == $past(i_boot_pins_a) && boot_b_q == $past(i_boot_pins_b);
  endproperty
  a_boot_cap: assert property (p_boot_cap) else $error("boot pins not captured at release");

  property p_boot_ro;
    @(posedge i_clock) disable iff (i_rst)
      boot_done_q |=> $stable(boot_a_q) && $stable(boot_b_q);
  endproperty
  a_boot_ro: assert property (p_boot_ro) else $error("boot capture changed after release");

  property p_hpi_wr;
    @(posedge i_clock) disable iff (i_rst)
      wr_en && idx_q == REG_HPI |=> o_host_enable == $past(i_hwdata[`DCPM_HPI_EN])
        && o_host_nonmux == $past(i_hwdata[`DCPM_HPI_HOST_NONMUX_MODE_BIT]);
  endproperty
  a_hpi_wr: assert property (p_hpi_wr) else $error("host port config write lost");

  property p_addr_valid;
    @(posedge i_clock) disable iff (i_rst)
      (o_host_nonmux || hpi_q[`DCPM_HPI_SEC]) ##1 (o_host_nonmux || hpi_q[`DCPM_HPI_SEC]) |-> o_host_addr_valid;
  endproperty
  a_addr_valid: assert property (p_addr_valid) else $error("upper address not enabled");

  property p_mid_wr;
    @(posedge i_clock) disable iff (i_rst)
      wr_en && idx_q == REG_AUMB |=> o_host_addr_mid == $past(i_hwdata[7:0]);
  endproperty
  a_mid_wr: assert property (p_mid_wr) else $error("upper middle byte write lost");

  property p_cap_trig;
    @(posedge i_clock) disable iff (i_rst)
      tcs_q[2:0] < `DCPM_NUM_EVENTS |=> o_capture_trig[0] == $past(i_audio_dma_events[tcs_q[2:0]]);
  endproperty
  a_cap_trig: assert property (p_cap_trig) else $error("capture channel 0 wrong event");

  property p_mute;
    @(posedge i_clock) disable iff (i_rst)
      1'b1 |=> o_audio_mute_in[1] == $past(i_mute_pins[mute_q[1]]);
  endproperty
  a_mute: assert property (p_mute) else $error("mute input 1 wrong pin");

  property p_bridge;
    @(posedge i_clock) disable iff (i_rst)
      wr_en && idx_q == REG_BRIDGE |=> o_bridge_reset == $past(i_hwdata[0]);
  endproperty
  a_bridge: assert property (p_bridge) else $error("bridge reset not updated");

  property p_opt2;
    @(posedge i_clock) disable iff (i_rst)
      sp0_opt == SP0_I2C1 && i_i2c_oe[2] |=> !o_sp0_pin_oe_n[2] && o_sp0_pin_out[2] == $past(i_i2c_out[2]);
  endproperty
  a_opt2: assert property (p_opt2) else $error("I2C1 lost chip-select pin");

  property p_status;
    @(posedge i_clock) disable iff (i_rst)
      rd_q && idx_q == REG_STATUS && sp1_mode == SP1_OFF |=> o_hrdata[4:0] == `DCPM_A0_OFF && o_hreadyout;
  endproperty
  a_status: assert property (p_status) else $error("audio pin limit wrong");

  property p_owner;
    @(posedge i_clock) disable iff (i_rst)
      own_x[10] && i_sec_oe[10] |=> !o_ax_pin_oe_n[10] && o_ax_pin_out[10] == $past(i_sec_out[10]);
  endproperty
  a_owner: assert property (p_owner) else $error("owner select ignored");

  property p_wide;
    @(posedge i_clock) disable iff (i_rst)
      !o_host_nonmux && i_mem_oe_hi |=> o_md_pin_oe_n == 16'h0000 && o_md_pin_out == $past(i_mem_out_hi);
  endproperty
  a_wide: assert property (p_wide) else $error("memory upper data not driven");

  property p_nonmux;
    @(posedge i_clock) disable iff (i_rst)
      o_host_nonmux |=> o_md_pin_oe_n == 16'hFFFF;
  endproperty
  a_nonmux: assert property (p_nonmux) else $error("upper data driven in nonmux");

  property p_anyout;
    @(posedge i_clock) disable iff (i_rst)
      1'b1 |=> ~o_sp0_pin_oe_n == $past(spi0_req | i2c_req);
  endproperty
  a_anyout: assert property (p_anyout) else $error("shared pin direction wrong");
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the device config registers and pin multiplexer
`timescale 1ns/1ns
`include "dcpm_regs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module tb;
  logic i_clock, i_rst, i_hsel, i_hwrite, i_hready, i_simo_oe, i_simo_out, i_mem_oe_hi;
  logic [31:0] i_haddr, i_hwdata, o_hrdata;
  logic [1:0] i_htrans, o_capture_trig;
  logic [2:0] i_hsize, o_audio_mute_in;
  logic [7:0] i_boot_pins_a, i_boot_pins_b, i_mute_pins, o_host_addr_top, o_host_addr_mid;
  logic [5:0] i_audio_dma_events;
  logic [3:0] i_sp0_oe, i_sp0_out, i_i2c_oe, i_i2c_out, i_sp0_pin_in, o_sp0_pin_out, o_sp0_pin_oe_n, o_sp0_pin_sync;
  logic [10:0] i_au0_oe, i_au0_out, i_sec_oe, i_sec_out, i_ax_pin_in, o_ax_pin_out, o_ax_pin_oe_n, o_ax_pin_sync;
  logic [4:0] i_sp1_oe, i_sp1_out;
  logic [15:0] i_mem_out_hi, i_md_pin_in, o_md_pin_out, o_md_pin_oe_n, o_md_pin_sync;
  logic o_hreadyout, o_hresp, o_host_enable, o_host_nonmux, o_host_halfword, o_host_addr_valid;
  logic o_bridge_reset, o_simo_pin_out, o_simo_pin_oe_n, o_mem_wide;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] a0_max [5] = '{32'h0000000B, 32'h0000000C, 32'h0000000C, 32'h0000000D, 32'h00000010};
  logic [31:0] a1_max [5] = '{32'h00000004, 32'h00000004, 32'h00000004, 32'h00000004, 32'h00000006};

  assign i_hready = o_hreadyout;

  dcpm_top u_dcpm_top (.i_clock, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
    .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_boot_pins_a, .i_boot_pins_b, .o_host_enable,
    .o_host_nonmux, .o_host_halfword, .o_host_addr_valid, .o_host_addr_top, .o_host_addr_mid,
    .i_audio_dma_events, .o_capture_trig, .i_mute_pins, .o_audio_mute_in, .o_bridge_reset, .i_sp0_oe,
    .i_sp0_out, .i_i2c_oe, .i_i2c_out, .i_sp0_pin_in, .o_sp0_pin_out, .o_sp0_pin_oe_n, .o_sp0_pin_sync,
    .i_simo_oe, .i_simo_out, .o_simo_pin_out, .o_simo_pin_oe_n, .i_au0_oe, .i_au0_out, .i_sec_oe,
    .i_sec_out, .i_sp1_oe, .i_sp1_out, .i_ax_pin_in, .o_ax_pin_out, .o_ax_pin_oe_n, .o_ax_pin_sync,
    .i_mem_oe_hi, .i_mem_out_hi, .i_md_pin_in, .o_md_pin_out, .o_md_pin_oe_n, .o_md_pin_sync, .o_mem_wide);

  always #20 i_clock = ~i_clock;

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // Ready read just after an edge is the value that edge sampled
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_htrans <= 2'b10;
    i_hwrite <= wr;
    i_hsize <= 3'b010;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 50);
    i_htrans <= 2'b00;
    i_hsel <= 1'b0;
    i_hwdata <= wd;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 50);
    rd = o_hrdata;
    if (n >= 50) begin
      fail_count++;
      $display("unexpected at %0t: bus hung", $time);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h00000000, x);
    `CHK(x, e)
    `CHK(o_hresp, 1'b0)
  endtask

  task automatic stop_test();
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #400000;
    fail_count++;
    stop_test();
  end

  initial begin
    {i_clock, i_hsel, i_hwrite, i_simo_oe, i_simo_out, i_mem_oe_hi} = '0;
    {i_haddr, i_hwdata, i_htrans, i_hsize, i_audio_dma_events, i_mute_pins} = '0;
    {i_sp0_oe, i_sp0_out, i_i2c_oe, i_i2c_out, i_sp0_pin_in, i_sp1_oe, i_sp1_out} = '0;
    {i_au0_oe, i_au0_out, i_sec_oe, i_sec_out, i_ax_pin_in, i_mem_out_hi, i_md_pin_in} = '0;
    i_boot_pins_a = 8'hA5;
    i_boot_pins_b = 8'h3C;
    i_rst = 1'b1;
    tick(3);
    i_rst <= 1'b0;
    tick(1);
    i_boot_pins_a <= 8'h00;
    i_boot_pins_b <= 8'hFF;
    // Reset values, boot capture, ignored boot writes, unmapped place
    rd(`DCPM_ADDR_BOOT_A, 32'h000000A5);
    rd(`DCPM_ADDR_BOOT_B, 32'h0000003C);
    wr(`DCPM_ADDR_BOOT_A, 32'hFFFFFFFF);
    rd(`DCPM_ADDR_BOOT_A, 32'h000000A5);
    rd(`DCPM_ADDR_HPI, 32'h00000000);
    rd(`DCPM_ADDR_TCS, 32'h00000077);
    rd(`DCPM_ADDR_PINOPT, 32'h00000010);
    rd(`DCPM_ADDR_STATUS, 32'h00000610);
    wr(32'h40000030, 32'hFFFFFFFF);
    rd(32'h40000030, 32'h00000000);
    // Host port config and address bytes, back to back
    wr(`DCPM_ADDR_AMSB, 32'h0000005A);
    wr(`DCPM_ADDR_AUMB, 32'h000000C3);
    wr(`DCPM_ADDR_HPI, 32'h00000005);
    tick(2);
    `CHK({o_host_halfword, o_host_nonmux, o_host_enable, o_host_addr_valid}, 4'b1010)
    `CHK({o_host_addr_top, o_host_addr_mid}, 16'h5AC3)
    `CHK(o_mem_wide, 1'b1)
    i_mem_oe_hi <= 1'b1;
    i_mem_out_hi <= 16'hBEEF;
    i_md_pin_in <= 16'h1234;
    tick(2);
    `CHK({o_md_pin_out, o_md_pin_oe_n}, 32'hBEEF0000)
    `CHK(o_md_pin_sync, 16'h1234)
    wr(`DCPM_ADDR_HPI, 32'h00000008);
    tick(2);
    `CHK(o_host_addr_valid, 1'b1)
    wr(`DCPM_ADDR_HPI, 32'h00000003);
    tick(2);
    `CHK({o_mem_wide, o_md_pin_oe_n, o_host_addr_valid}, 18'h1FFFF)
    `CHK(o_md_pin_sync, 16'h1234)
    rd(`DCPM_ADDR_HPI, 32'h00000003);
    // Timer capture channel sources over all six events
    for (int k = 0; k < 6; k++) begin
      wr(`DCPM_ADDR_TCS, (32'(5 - k) << 4) | 32'(k));
      i_audio_dma_events <= 6'(1 << k);
      tick(2);
      `CHK(o_capture_trig, 2'b01)
      i_audio_dma_events <= 6'(1 << (5 - k));
      tick(2);
      `CHK(o_capture_trig, 2'b10)
    end
    wr(`DCPM_ADDR_TCS, 32'h00000077);
    i_audio_dma_events <= 6'h3F;
    tick(2);
    `CHK(o_capture_trig, 2'b00)
    // Mute pin per audio port
    for (int p = 0; p < 3; p++) begin
      wr(`DCPM_ADDR_MUTE0 + 32'(4 * p), 32'(3 * p + 1));
      i_mute_pins <= 8'(1 << (3 * p + 1));
      tick(2);
      `CHK(o_audio_mute_in, 3'(1 << p))
    end
    rd(`DCPM_ADDR_MUTE2, 32'h00000007);
    wr(`DCPM_ADDR_BRIDGE, 32'h00000001);
    tick(2);
    `CHK(o_bridge_reset, 1'b1)
    wr(`DCPM_ADDR_BRIDGE, 32'h00000000);
    tick(2);
    `CHK(o_bridge_reset, 1'b0)
    // Serial port 0 options with both sharers asking to drive
    i_sp0_oe <= 4'hF;
    i_sp0_out <= 4'h5;
    i_i2c_oe <= 4'hF;
    i_i2c_out <= 4'hA;
    i_sp0_pin_in <= 4'h6;
    i_simo_oe <= 1'b1;
    i_simo_out <= 1'b1;
    wr(`DCPM_ADDR_PINOPT, 32'h00000010);
    tick(2);
    `CHK({o_sp0_pin_out, o_sp0_pin_oe_n, o_sp0_pin_sync}, 12'h506)
    `CHK({o_simo_pin_out, o_simo_pin_oe_n}, 2'b10)
    wr(`DCPM_ADDR_PINOPT, 32'h00000011);
    tick(2);
    `CHK(o_sp0_pin_out, 4'h9)
    wr(`DCPM_ADDR_PINOPT, 32'h00000012);
    tick(2);
    `CHK({o_sp0_pin_out, o_sp0_pin_oe_n}, 8'hA0)
    `CHK({o_simo_pin_out, o_simo_pin_oe_n}, 2'b10)
    i_i2c_oe <= 4'h0;
    tick(2);
    `CHK(o_sp0_pin_oe_n, 4'hF)
    // Serial port 1 modes against audio pin limits and per-pin owners
    i_sp1_oe <= 5'h1F;
    i_au0_oe <= 11'h7FF;
    i_au0_out <= 11'h7FF;
    i_ax_pin_in <= 11'h2A5;
    for (int m = 0; m < 5; m++) begin
      wr(`DCPM_ADDR_PINOPT, 32'(m << 2));
      rd(`DCPM_ADDR_STATUS, (a1_max[m] << 8) | a0_max[m]);
    end
    wr(`DCPM_ADDR_PINOPT, 32'h00000000);
    tick(2);
    `CHK({o_ax_pin_out, o_ax_pin_oe_n}, {11'h7E0, 11'h000})
    `CHK(o_ax_pin_sync, 11'h2A5)
    wr(`DCPM_ADDR_PINOPT, 32'h00000010);
    tick(2);
    `CHK(o_ax_pin_out, 11'h7FF)
    i_sec_oe <= 11'h7F8;
    wr(`DCPM_ADDR_PINOPT, 32'h0000A510);
    tick(2);
    `CHK({o_ax_pin_out, o_ax_pin_oe_n}, {11'h2D7, 11'h000})
    // Second reset mid-run captures fresh strap levels
    i_boot_pins_a <= 8'h5A;
    i_boot_pins_b <= 8'hC3;
    i_rst <= 1'b1;
    tick(2);
    `CHK({o_ax_pin_oe_n, o_mem_wide, o_bridge_reset}, 13'h1FFE)
    i_rst <= 1'b0;
    tick(2);
    rd(`DCPM_ADDR_BOOT_A, 32'h0000005A);
    rd(`DCPM_ADDR_BOOT_B, 32'h000000C3);
    stop_test();
  end
endmodule
